// ===== hdl/phy_vendor_pkg.sv
// Purpose: constants and types shared by the vendor register bank and its address matcher
// Assumes: 16-bit management registers, five-bit management register select
// Notes: monitor codes follow the auto-negotiation debug encoding
package phy_vendor_pkg;

  localparam logic [4:0] REG_VENDOR_CONFIG = 5'h10;
  localparam logic [4:0] REG_VENDOR_CONFIG_STATUS = 5'h11;

  // vendor_config fields
  localparam int SLEEP_BIT = 1;
  localparam int REMOTE_LOOP_OUT_BIT = 0;
  localparam logic SLEEP_RESET = 1'b0;
  localparam logic REMOTE_LOOP_OUT_RESET = 1'b0;

  // vendor_config_status fields
  localparam int RES_MODE_LSB = 12;
  localparam int RSV_LSB = 10;
  localparam int PHY_ADDR_LSB = 4;
  localparam int MON_LSB = 0;
  localparam logic [3:0] RES_MODE_RESET = 4'hf;
  localparam logic [1:0] RSV_RESET = 2'h0;
  localparam logic [4:0] PHY_ADDR_RESET = 5'h00;
  localparam logic [4:0] PHY_ADDR_ISOLATE = 5'h00;
  localparam logic [3:0] MON_RESET = 4'h0;

  // monitor codes
  localparam logic [3:0] MON_IDLE = 4'h0;
  localparam logic [3:0] MON_ABILITY_MATCH = 4'h1;
  localparam logic [3:0] MON_ACK_MATCH = 4'h2;
  localparam logic [3:0] MON_ACK_FAIL = 4'h3;
  localparam logic [3:0] MON_CONS_MATCH = 4'h4;
  localparam logic [3:0] MON_CONS_FAIL = 4'h5;
  localparam logic [3:0] MON_PD_READY = 4'h6;
  localparam logic [3:0] MON_PD_FAIL = 4'h7;
  localparam logic [3:0] MON_DONE = 4'h8;

  // cycles the strap sample waits after reset release
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam int ADDR_BITS = 5;
  localparam logic [2:0] ADDR_LAST = 3'h4;

  typedef enum logic [8:0] {
    AN_IDLE = 9'h001,
    AN_ABILITY = 9'h002,
    AN_ACK = 9'h004,
    AN_ACK_FAIL = 9'h008,
    AN_CONS = 9'h010,
    AN_CONS_FAIL = 9'h020,
    AN_PD_READY = 9'h040,
    AN_PD_FAIL = 9'h080,
    AN_DONE = 9'h100
  } an_state_t;

  typedef enum logic [2:0] {
    PWR_AWAKE = 3'b001,
    PWR_SLEEP = 3'b010,
    PWR_WAKE = 3'b100
  } pwr_state_t;

endpackage

// ===== hdl/mgmt_addr_if.sv
// Purpose: carries management frame address bits to the address matcher
// Assumes: one bit per bit_valid pulse, most significant first
// Notes: clear restarts the matcher like a frame start
`timescale 1ns/1ns
`default_nettype none
interface mgmt_addr_if;
  logic frame_start;
  logic addr_bit;
  logic bit_valid;
  logic clear;
  logic [4:0] my_addr;
  logic match;

  modport matcher (
    input frame_start,
    input addr_bit,
    input bit_valid,
    input clear,
    input my_addr,
    output match
  );

  modport owner (
    output frame_start,
    output addr_bit,
    output bit_valid,
    output clear,
    output my_addr,
    input match
  );
endinterface
`default_nettype wire

// ===== hdl/mgmt_addr_match.sv
// Purpose: collects the five frame address bits and compares them with the own address
// Assumes: bits arrive on the clock of the register bank
// Notes: match holds until the next frame start or clear
`timescale 1ns/1ns
`default_nettype none
module mgmt_addr_match (
  input wire logic clk,
  input wire logic rst_n,
  mgmt_addr_if.matcher ai
);
  import phy_vendor_pkg::*;

  logic [2:0] cnt_q;
  logic [4:0] shift_q;
  logic match_q;
  logic [4:0] next_shift;

  // first bit in lands at the top: address bit 4 first
  assign next_shift = {shift_q[3:0], ai.addr_bit};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      shift_q <= 5'h00;
    end else if (ai.frame_start || ai.clear) begin
      cnt_q <= 3'h0;
      shift_q <= 5'h00;
    end else if (ai.bit_valid && cnt_q <= ADDR_LAST) begin
      cnt_q <= cnt_q + 3'h1;
      shift_q <= next_shift;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      match_q <= 1'b0;
    end else if (ai.frame_start || ai.clear) begin
      match_q <= 1'b0;
    end else if (ai.bit_valid && cnt_q == ADDR_LAST) begin
      match_q <= (next_shift == ai.my_addr);
    end
  end

  assign ai.match = match_q;
endmodule
`default_nettype wire

// ===== hdl/phy_vendor_regs.sv
// Purpose: vendor configuration and status registers of a 10/100 transceiver
// Assumes: register port driven by the management frame engine on clk
// Notes: strap pins are sampled after a two-flop synchroniser
`timescale 1ns/1ns
`default_nettype none
module phy_vendor_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] reg_sel,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [4:0] phy_addr_strap,
  input wire logic frame_start,
  input wire logic frame_addr_bit,
  input wire logic frame_addr_valid,
  output logic addr_match,
  input wire phy_vendor_pkg::an_state_t an_state,
  input wire logic an_complete,
  input wire logic [3:0] an_resolved,
  input wire logic [3:0] rx_data,
  input wire logic rx_valid,
  input wire logic [3:0] mac_tx_data,
  input wire logic mac_tx_en,
  output logic [3:0] tx_data,
  output logic tx_en,
  output logic power_down,
  output logic sm_reset,
  output logic isolate_set
);
  import phy_vendor_pkg::*;

  function automatic logic reg_write(input logic [4:0] sel, input logic wr,
                                     input logic [4:0] off);
    reg_write = wr && (sel == off);
  endfunction

  function automatic logic [3:0] an_code(input an_state_t st);
    case (st)
      AN_IDLE: an_code = MON_IDLE;
      AN_ABILITY: an_code = MON_ABILITY_MATCH;
      AN_ACK: an_code = MON_ACK_MATCH;
      AN_ACK_FAIL: an_code = MON_ACK_FAIL;
      AN_CONS: an_code = MON_CONS_MATCH;
      AN_CONS_FAIL: an_code = MON_CONS_FAIL;
      AN_PD_READY: an_code = MON_PD_READY;
      AN_PD_FAIL: an_code = MON_PD_FAIL;
      AN_DONE: an_code = MON_DONE;
      default: an_code = MON_IDLE;
    endcase
  endfunction

  logic wr_cfg;
  logic wr_stat;
  pwr_state_t pwr_q;
  pwr_state_t pwr_d;
  logic loop_q;
  logic [3:0] res_q;
  logic [1:0] rsv_q;
  logic [4:0] phy_addr_q;
  logic [3:0] mon_q;
  logic [4:0] strap_meta_q;
  logic [4:0] strap_sync_q;
  logic [1:0] strap_cnt_q;
  logic strap_done_q;
  logic strap_load;
  logic [15:0] rdata_q;
  logic [3:0] tx_data_q;
  logic tx_en_q;
  logic isolate_q;
  mgmt_addr_if ai ();

  assign wr_cfg = reg_write(reg_sel, reg_wr, REG_VENDOR_CONFIG);
  assign wr_stat = reg_write(reg_sel, reg_wr, REG_VENDOR_CONFIG_STATUS);

  // power state: sleep held in the state itself, wake is a one-cycle reset pass
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      PWR_AWAKE: begin
        if (wr_cfg && reg_wdata[SLEEP_BIT]) begin
          pwr_d = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (wr_cfg && !reg_wdata[SLEEP_BIT]) begin
          pwr_d = PWR_WAKE;
        end
      end
      PWR_WAKE: begin
        pwr_d = (wr_cfg && reg_wdata[SLEEP_BIT]) ? PWR_SLEEP : PWR_AWAKE;
      end
      default: pwr_d = PWR_AWAKE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= PWR_AWAKE;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  // power_down and sm_reset are state flop bits, no decode glitches
  assign power_down = pwr_q[1];
  assign sm_reset = pwr_q[2];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_q <= REMOTE_LOOP_OUT_RESET;
    end else if (wr_cfg) begin
      loop_q <= reg_wdata[REMOTE_LOOP_OUT_BIT];
    end
  end

  // transmit mux; goes silent one cycle after power_down rises since the transmitter is unpowered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_q <= 4'h0;
      tx_en_q <= 1'b0;
    end else if (power_down) begin
      tx_data_q <= 4'h0;
      tx_en_q <= 1'b0;
    end else if (loop_q) begin
      tx_data_q <= rx_data;
      tx_en_q <= rx_valid;
    end else begin
      tx_data_q <= mac_tx_data;
      tx_en_q <= mac_tx_en;
    end
  end

  assign tx_data = tx_data_q;
  assign tx_en = tx_en_q;

  // resolved mode is status, not configuration, so software writes never touch it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_q <= RES_MODE_RESET;
    end else if (an_complete) begin
      res_q <= an_resolved;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsv_q <= RSV_RESET;
    end else if (wr_stat) begin
      rsv_q <= reg_wdata[RSV_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_meta_q <= 5'h00;
      strap_sync_q <= 5'h00;
    end else begin
      strap_meta_q <= phy_addr_strap;
      strap_sync_q <= strap_meta_q;
    end
  end

  // wait until the synchroniser holds real pin values before sampling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      if (strap_cnt_q == STRAP_SETTLE) begin
        strap_done_q <= 1'b1;
      end else begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end

  assign strap_load = !strap_done_q && (strap_cnt_q == STRAP_SETTLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phy_addr_q <= PHY_ADDR_RESET;
    end else if (strap_load) begin
      phy_addr_q <= strap_sync_q;
    end else if (wr_stat) begin
      phy_addr_q <= reg_wdata[PHY_ADDR_LSB +: 5];
    end
  end

  // held off until the strap is in, so a nonzero strap never flashes isolate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      isolate_q <= 1'b0;
    end else begin
      isolate_q <= strap_done_q && (phy_addr_q == PHY_ADDR_ISOLATE);
    end
  end

  assign isolate_set = isolate_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_q <= MON_RESET;
    end else begin
      mon_q <= an_code(an_state);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      case (reg_sel)
        REG_VENDOR_CONFIG: rdata_q <= {14'h0000, pwr_q == PWR_SLEEP, loop_q};
        REG_VENDOR_CONFIG_STATUS: rdata_q <= {res_q, rsv_q, 1'b0, phy_addr_q, mon_q};
        default: rdata_q <= 16'h0000;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  assign ai.frame_start = frame_start;
  assign ai.addr_bit = frame_addr_bit;
  assign ai.bit_valid = frame_addr_valid;
  assign ai.clear = sm_reset;
  assign ai.my_addr = phy_addr_q;
  assign addr_match = ai.match;

  mgmt_addr_match u_match (
    .clk(clk),
    .rst_n(rst_n),
    .ai(ai)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_sleep_exit;
    pwr_q == PWR_SLEEP && wr_cfg && !reg_wdata[SLEEP_BIT];
  endsequence

  sequence seq_wake_pass;
    sm_reset && power_down == 1'b0;
  endsequence

  chk_sleep_entry: assert property (
    pwr_q == PWR_AWAKE && wr_cfg && reg_wdata[SLEEP_BIT] |=> power_down ##1 !tx_en)
    else $error("sleep write did not power down");

  chk_sleep_exit: assert property (
    seq_sleep_exit |=> seq_wake_pass ##1 !sm_reset)
    else $error("sleep exit did not pass through one reset cycle");

  chk_config_kept: assert property (
    seq_sleep_exit ##1 sm_reset |->
      loop_q == $past(reg_wdata[REMOTE_LOOP_OUT_BIT]) && $stable(phy_addr_q))
    else $error("configuration changed on wake");

  chk_loop_path: assert property (
    loop_q && !power_down |=> tx_data == $past(rx_data) && tx_en == $past(rx_valid))
    else $error("remote loop-out did not return receive data");

  chk_resolve_load: assert property (
    an_complete |=> ##1 rdata_q[RES_MODE_LSB +: 4] == $past(an_resolved, 2)
      || $past(reg_sel) != REG_VENDOR_CONFIG_STATUS)
    else $error("resolved mode not reported");

  chk_resolve_hold: assert property (
    !an_complete |=> $stable(res_q))
    else $error("resolved mode changed without completion");

  chk_strap_load: assert property (
    $rose(strap_done_q) |-> phy_addr_q == $past(strap_sync_q))
    else $error("strap address not loaded");

  chk_isolate_zero: assert property (
    strap_done_q && phy_addr_q == PHY_ADDR_ISOLATE |=> isolate_set)
    else $error("zero address did not isolate");

  chk_monitor_idle: assert property (
    an_state == AN_IDLE |=> mon_q == MON_IDLE)
    else $error("monitor not zero in idle");

  chk_monitor_done: assert property (
    an_state == AN_DONE |=> mon_q == MON_DONE ##1
      ($past(an_state) != AN_DONE || mon_q == MON_DONE))
    else $error("monitor wrong for completion");

  chk_monitor_ability: assert property (
    an_state == AN_ABILITY |=> mon_q == MON_ABILITY_MATCH)
    else $error("monitor wrong for ability match");
endmodule
`default_nettype wire

// ===== sim/mgmt_station_model.sv
// Purpose: station management side of the vendor register bank
// Assumes: register port and frame address bits driven at the falling clock edge
// Notes: idle data lines carry the inverse of their last value, never a stale copy
`timescale 1ns/1ns
`default_nettype none
module mgmt_station_model (
  input wire logic clk,
  output logic [4:0] reg_sel,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  output logic frame_start,
  output logic frame_addr_bit,
  output logic frame_addr_valid
);
  import phy_vendor_pkg::*;

  initial begin
    reg_sel = 5'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    frame_start = 1'b0;
    frame_addr_bit = 1'b0;
    frame_addr_valid = 1'b0;
  end

  task automatic wr(input logic [4:0] sel, input logic [15:0] wd);
    @(negedge clk);
    reg_sel = sel;
    // reserved status bits always go out as zero
    reg_wdata = (sel == REG_VENDOR_CONFIG_STATUS) ? (wd & 16'hf3ff) : wd;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask

  // read data is registered, so two edges pass before sampling
  task automatic rd(input logic [4:0] sel, output logic [15:0] rdv);
    @(negedge clk);
    reg_sel = sel;
    repeat (2) @(negedge clk);
    rdv = reg_rdata;
  endtask

  // caller passes the address to send, which need not be this device's own
  task automatic send_addr(input logic [4:0] a);
    @(negedge clk);
    frame_start = 1'b1;
    @(negedge clk);
    frame_start = 1'b0;
    for (int i = 4; i >= 0; i--) begin
      frame_addr_bit = a[i];
      frame_addr_valid = 1'b1;
      @(negedge clk);
    end
    frame_addr_valid = 1'b0;
    frame_addr_bit = ~frame_addr_bit;
  endtask
endmodule
`default_nettype wire

// ===== sim/phy_vendor_config_status_regs_tb.sv
// Purpose: self-checking bench for the vendor configuration and status registers
// Assumes: inputs change at the falling edge, reset held for ten cycles
// Notes: sm_reset is counted rather than timed, its exact edge is left open
`timescale 1ns/1ns
`default_nettype none
module phy_vendor_config_status_regs_tb;
  import phy_vendor_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] reg_sel;
  logic reg_wr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [4:0] phy_addr_strap = 5'h0a;
  logic frame_start;
  logic frame_addr_bit;
  logic frame_addr_valid;
  logic addr_match;
  an_state_t an_state = AN_IDLE;
  logic an_complete = 1'b0;
  logic [3:0] an_resolved = 4'h0;
  logic [3:0] rx_data = 4'h0;
  logic rx_valid = 1'b0;
  logic [3:0] mac_tx_data = 4'h0;
  logic mac_tx_en = 1'b0;
  logic [3:0] tx_data;
  logic tx_en;
  logic power_down;
  logic sm_reset;
  logic isolate_set;
  int failures = 0;
  int comparisons = 0;
  int smr_cnt = 0;
  an_state_t st [9] = '{AN_IDLE, AN_ABILITY, AN_ACK, AN_ACK_FAIL, AN_CONS,
                        AN_CONS_FAIL, AN_PD_READY, AN_PD_FAIL, AN_DONE};

  always #2 clk = ~clk;

  // counted at the falling edge, where the flop output has settled
  always @(negedge clk) begin
    if (sm_reset === 1'b1) begin
      smr_cnt++;
    end
  end

  mgmt_station_model mgr (
    .clk(clk), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .frame_start(frame_start), .frame_addr_bit(frame_addr_bit),
    .frame_addr_valid(frame_addr_valid)
  );

  phy_vendor_regs dut (
    .clk(clk), .rst_n(rst_n), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .phy_addr_strap(phy_addr_strap), .frame_start(frame_start),
    .frame_addr_bit(frame_addr_bit), .frame_addr_valid(frame_addr_valid),
    .addr_match(addr_match), .an_state(an_state), .an_complete(an_complete),
    .an_resolved(an_resolved), .rx_data(rx_data), .rx_valid(rx_valid),
    .mac_tx_data(mac_tx_data), .mac_tx_en(mac_tx_en), .tx_data(tx_data), .tx_en(tx_en),
    .power_down(power_down), .sm_reset(sm_reset), .isolate_set(isolate_set)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard, far beyond the length of the main sequence
  initial begin
    for (int c = 0; c < 5000; c++) begin
      @(posedge clk);
    end
    failures++;
    stop_test();
  end

  initial begin
    logic [15:0] v;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    mgr.rd(REG_VENDOR_CONFIG_STATUS, v);
    chk(v, 16'hf0a0);
    chk({15'h0000, isolate_set}, 16'h0000);
    mgr.rd(REG_VENDOR_CONFIG, v);
    chk(v, 16'h0000);
    mgr.wr(5'h05, 16'hffff);
    mgr.rd(5'h05, v);
    chk(v, 16'h0000);
    chk({15'h0000, power_down}, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      @(negedge clk);
      an_state = st[i];
      mgr.rd(REG_VENDOR_CONFIG_STATUS, v);
      chk({12'h000, v[3:0]}, {12'h000, 4'(i)});
    end
    // flags only read once negotiation has run
    @(negedge clk);
    an_resolved = 4'h4;
    an_complete = 1'b1;
    @(negedge clk);
    an_complete = 1'b0;
    an_resolved = 4'hb;
    mgr.rd(REG_VENDOR_CONFIG_STATUS, v);
    chk(v, 16'h40a8);
    mgr.wr(REG_VENDOR_CONFIG_STATUS, 16'hf000);
    repeat (3) @(negedge clk);
    chk({15'h0000, isolate_set}, 16'h0001);
    mgr.wr(REG_VENDOR_CONFIG_STATUS, 16'hf160);
    mgr.rd(REG_VENDOR_CONFIG_STATUS, v);
    chk(v, 16'h4168);
    chk({15'h0000, isolate_set}, 16'h0000);
    // 0x16 reversed is 0x0d, so a wrong bit order shows
    mgr.send_addr(5'h16);
    @(negedge clk);
    chk({15'h0000, addr_match}, 16'h0001);
    mgr.send_addr(5'h0d);
    @(negedge clk);
    chk({15'h0000, addr_match}, 16'h0000);
    rx_data = 4'ha;
    rx_valid = 1'b1;
    mac_tx_data = 4'h5;
    mac_tx_en = 1'b1;
    mgr.wr(REG_VENDOR_CONFIG, 16'h0001);
    repeat (2) @(negedge clk);
    chk({11'h000, tx_en, tx_data}, 16'h001a);
    smr_cnt = 0;
    mgr.wr(REG_VENDOR_CONFIG, 16'h0003);
    repeat (2) @(negedge clk);
    chk({15'h0000, power_down}, 16'h0001);
    chk({15'h0000, tx_en}, 16'h0000);
    mgr.rd(REG_VENDOR_CONFIG, v);
    chk(v, 16'h0003);
    mgr.wr(REG_VENDOR_CONFIG, 16'h0001);
    repeat (3) @(negedge clk);
    chk({15'h0000, power_down}, 16'h0000);
    chk(16'(smr_cnt), 16'h0001);
    mgr.rd(REG_VENDOR_CONFIG_STATUS, v);
    chk(v, 16'h4168);
    chk({11'h000, tx_en, tx_data}, 16'h001a);
    mgr.wr(REG_VENDOR_CONFIG, 16'h0000);
    repeat (2) @(negedge clk);
    chk({11'h000, tx_en, tx_data}, 16'h0015);
    stop_test();
  end
endmodule
`default_nettype wire
